// File: logic/ext_irq_map.svh
// Register addresses, field positions and reset values of the extended interrupt flags block
`ifndef EXT_IRQ_MAP_SVH
`define EXT_IRQ_MAP_SVH

`define SFR_ADDR_PENDING_FLAGS   8'hbf
`define SFR_ADDR_IRQ_ENABLE      8'he6
`define SFR_ADDR_IRQ_PRIORITY    8'hf6
`define SFR_ADDR_PIN_CONFIG      8'hb7

`define RST_PENDING_FLAGS        8'h00
`define RST_IRQ_ENABLE           8'h00
`define RST_IRQ_PRIORITY         8'h00
`define RST_PIN_CONFIG           8'h00

`define MASK_EXT_REG             8'h1c
`define MASK_FLAG_REG            8'h1f

`define BIT_SPARE_ONE            4
`define BIT_SPARE_ZERO           3
`define BIT_FREQ_COUNTER         2
`define BIT_SERIALIZER           2
`define BIT_EDGE_ONE             1
`define BIT_EDGE_ZERO            0

`define CFG_INVERT_ONE           7
`define CFG_SEL_ONE_HI           6
`define CFG_SEL_ONE_LO           4
`define CFG_INVERT_ZERO          3
`define CFG_SEL_ZERO_HI          2
`define CFG_SEL_ZERO_LO          0

`define PIN_CODE_ALT             3'h5
`define ALT_PIN_ZERO             8
`define ALT_PIN_ONE              9
`define GPIO_COUNT               10

`endif

// File: logic/ext_irq_pkg.sv
// Types shared by the extended interrupt flags block
package ext_irq_pkg;

    typedef logic [7:0] sfr_byte_t;
    typedef logic [2:0] pin_code_t;

    typedef enum logic
    {
        EDGE_SINGLE = 1'b0,
        EDGE_DUAL   = 1'b1
    } edge_mode_e;

endpackage : ext_irq_pkg

// File: logic/edge_cfg_if.sv
// Configuration and event signals between the flag block and one edge detector
`timescale 1ns/1ns
interface edge_cfg_if;
    import ext_irq_pkg::*;

    pin_code_t  pin_sel;
    logic       invert;
    edge_mode_e mode;
    logic       event_pulse;

    modport ctrl (output pin_sel, output invert, output mode, input event_pulse);
    modport det  (input pin_sel, input invert, input mode, output event_pulse);
endinterface : edge_cfg_if

// File: logic/edge_detect.sv
// Pin selection, polarity and edge detection for one external edge source
`timescale 1ns/1ns
`include "ext_irq_map.svh"
module edge_detect
    import ext_irq_pkg::*;
#(
    parameter int ALT_PIN = `ALT_PIN_ZERO
)
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [`GPIO_COUNT-1:0] i_gpio_sync,
    edge_cfg_if.det                     cfg
);

    function automatic logic pick_pin(input logic [`GPIO_COUNT-1:0] pins, input pin_code_t code);
        logic bit_out;
        bit_out = pins[code];
        if (code == `PIN_CODE_ALT)
        begin
            bit_out = pins[ALT_PIN];
        end
        return bit_out;
    endfunction : pick_pin

    logic level;
    logic prev_r;
    logic primed_r;
    logic event_r;
    logic rise;
    logic fall;
    logic hit;

    assign level = pick_pin(i_gpio_sync, cfg.pin_sel) ^ cfg.invert;
    assign rise  = level & ~prev_r;
    assign fall  = ~level & prev_r;
    // Only edges count, a steady level never fires; invert picks the active sense
    assign hit   = primed_r & (rise | ((cfg.mode == EDGE_DUAL) & fall));

    // First sample after reset only primes the history, but a pin held high still fires once it leaves the zero-reset synchronizer
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            prev_r   <= 1'b0;
            primed_r <= 1'b0;
            event_r  <= 1'b0;
        end
        else
        begin
            prev_r   <= level;
            primed_r <= 1'b1;
            event_r  <= hit;
        end
    end

    assign cfg.event_pulse = event_r;

endmodule : edge_detect

// File: logic/ext_irq_flags_and_masks.sv
// Extended interrupt enable, priority and pending flags with two external edge sources
`timescale 1ns/1ns
`include "ext_irq_map.svh"

module ext_irq_flags_and_masks
    import ext_irq_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_reset_n,
    input  wire logic [7:0]             i_sfr_addr,
    input  wire logic                   i_sfr_wr,
    input  wire logic [7:0]             i_sfr_wdata,
    input  wire logic [`GPIO_COUNT-1:0] i_gpio,
    input  wire logic                   i_global_irq_enable,
    input  wire logic                   i_edge_zero_irq_enable,
    input  wire logic                   i_edge_one_irq_enable,
    input  wire logic                   i_serializer_irq_enable,
    input  wire logic                   i_dual_edge_sel_zero,
    input  wire logic                   i_dual_edge_sel_one,
    input  wire logic                   i_freq_counter_flag,
    input  wire logic                   i_tx_holding_empty,
    output logic [7:0]                  o_sfr_rdata,
    output logic                        o_freq_counter_irq,
    output logic                        o_spare_zero_irq,
    output logic                        o_spare_one_irq,
    output logic                        o_serializer_irq,
    output logic                        o_edge_zero_irq,
    output logic                        o_edge_one_irq,
    output logic                        o_freq_counter_high_prio,
    output logic                        o_spare_zero_high_prio,
    output logic                        o_spare_one_high_prio,
    output logic                        o_capture_timer2,
    output logic                        o_capture_timer3
);

    sfr_byte_t flags_r;
    sfr_byte_t flags_nxt;
    sfr_byte_t enable_r;
    sfr_byte_t enable_nxt;
    sfr_byte_t priority_r;
    sfr_byte_t priority_nxt;
    sfr_byte_t pin_cfg_r;
    sfr_byte_t pin_cfg_nxt;
    sfr_byte_t rdata_nxt;
    sfr_byte_t hw_set;

    logic [`GPIO_COUNT-1:0] gpio_meta_r;
    logic [`GPIO_COUNT-1:0] gpio_sync_r;

    logic tx_empty_prev_r;
    logic tx_empty_rise;

    logic wr_flags;
    logic wr_enable;
    logic wr_priority;
    logic wr_pin_cfg;

    logic rd_flags;
    logic rd_enable;
    logic rd_priority;
    logic rd_pin_cfg;

    logic event_zero;
    logic event_one;

    logic freq_counter_req;
    logic spare_zero_req;
    logic spare_one_req;
    logic serializer_req;
    logic edge_zero_req;
    logic edge_one_req;

    logic freq_counter_irq_r;
    logic spare_zero_irq_r;
    logic spare_one_irq_r;
    logic serializer_irq_r;
    logic edge_zero_irq_r;
    logic edge_one_irq_r;
    logic capture_timer2_r;
    logic capture_timer3_r;
    sfr_byte_t rdata_r;

    edge_cfg_if cfg_zero ();
    edge_cfg_if cfg_one ();

    // Request qualification shared by every source
    function automatic logic gate_req(input logic pending, input logic enable, input logic global_en);
        return pending & enable & global_en;
    endfunction : gate_req

    // Register decode
    assign wr_flags    = i_sfr_wr & (i_sfr_addr == `SFR_ADDR_PENDING_FLAGS);
    assign wr_enable   = i_sfr_wr & (i_sfr_addr == `SFR_ADDR_IRQ_ENABLE);
    assign wr_priority = i_sfr_wr & (i_sfr_addr == `SFR_ADDR_IRQ_PRIORITY);
    assign wr_pin_cfg  = i_sfr_wr & (i_sfr_addr == `SFR_ADDR_PIN_CONFIG);

    assign rd_flags    = (i_sfr_addr == `SFR_ADDR_PENDING_FLAGS);
    assign rd_enable   = (i_sfr_addr == `SFR_ADDR_IRQ_ENABLE);
    assign rd_priority = (i_sfr_addr == `SFR_ADDR_IRQ_PRIORITY);
    assign rd_pin_cfg  = (i_sfr_addr == `SFR_ADDR_PIN_CONFIG);

    // Reserved upper bits are never stored, so they read back as zero
    assign enable_nxt   = wr_enable ? (i_sfr_wdata & `MASK_EXT_REG) : enable_r;
    assign priority_nxt = wr_priority ? (i_sfr_wdata & `MASK_EXT_REG) : priority_r;
    assign pin_cfg_nxt  = wr_pin_cfg ? i_sfr_wdata : pin_cfg_r;

    // Serializer flag fires once per transition to empty, not while it stays empty
    assign tx_empty_rise = i_tx_holding_empty & ~tx_empty_prev_r;

    // Hardware only ever sets flags; spare bits have no hardware source
    assign hw_set[7:5]                = 3'h0;
    assign hw_set[`BIT_SPARE_ONE]     = 1'b0;
    assign hw_set[`BIT_SPARE_ZERO]    = 1'b0;
    assign hw_set[`BIT_SERIALIZER]    = tx_empty_rise;
    assign hw_set[`BIT_EDGE_ONE]      = event_one;
    assign hw_set[`BIT_EDGE_ZERO]     = event_zero;

    // A hardware set in the same cycle as a software clear wins, so no event is lost
    assign flags_nxt = ((wr_flags ? i_sfr_wdata : flags_r) | hw_set) & `MASK_FLAG_REG;

    assign rdata_nxt = rd_flags    ? flags_r :
                       rd_enable   ? enable_r :
                       rd_priority ? priority_r :
                       rd_pin_cfg  ? pin_cfg_r :
                       8'h00;

    // Edge source configuration
    assign cfg_zero.pin_sel = pin_cfg_r[`CFG_SEL_ZERO_HI:`CFG_SEL_ZERO_LO];
    assign cfg_zero.invert  = pin_cfg_r[`CFG_INVERT_ZERO];
    assign cfg_zero.mode    = edge_mode_e'(i_dual_edge_sel_zero);
    assign cfg_one.pin_sel  = pin_cfg_r[`CFG_SEL_ONE_HI:`CFG_SEL_ONE_LO];
    assign cfg_one.invert   = pin_cfg_r[`CFG_INVERT_ONE];
    assign cfg_one.mode     = edge_mode_e'(i_dual_edge_sel_one);

    assign event_zero = cfg_zero.event_pulse;
    assign event_one  = cfg_one.event_pulse;

    // Requests toward the CPU
    assign freq_counter_req = gate_req(i_freq_counter_flag, enable_r[`BIT_FREQ_COUNTER], i_global_irq_enable);
    assign spare_zero_req   = gate_req(flags_r[`BIT_SPARE_ZERO], enable_r[`BIT_SPARE_ZERO], i_global_irq_enable);
    assign spare_one_req    = gate_req(flags_r[`BIT_SPARE_ONE], enable_r[`BIT_SPARE_ONE], i_global_irq_enable);
    assign serializer_req   = gate_req(flags_r[`BIT_SERIALIZER], i_serializer_irq_enable, i_global_irq_enable);
    assign edge_zero_req    = gate_req(flags_r[`BIT_EDGE_ZERO], i_edge_zero_irq_enable, i_global_irq_enable);
    assign edge_one_req     = gate_req(flags_r[`BIT_EDGE_ONE], i_edge_one_irq_enable, i_global_irq_enable);

    // Pins cross into the system clock here; the slower that clock, the later an edge is seen
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            gpio_meta_r <= '0;
            gpio_sync_r <= '0;
        end
        else
        begin
            gpio_meta_r <= i_gpio;
            gpio_sync_r <= gpio_meta_r;
        end
    end

    edge_detect #(
        .ALT_PIN     (`ALT_PIN_ZERO)
    ) u_edge_zero (
        .i_ref_clk   (i_ref_clk),
        .i_reset_n   (i_reset_n),
        .i_gpio_sync (gpio_sync_r),
        .cfg         (cfg_zero.det)
    );

    edge_detect #(
        .ALT_PIN     (`ALT_PIN_ONE)
    ) u_edge_one (
        .i_ref_clk   (i_ref_clk),
        .i_reset_n   (i_reset_n),
        .i_gpio_sync (gpio_sync_r),
        .cfg         (cfg_one.det)
    );

    // Pending flags: hardware sets and software writes meet only in flags_nxt
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            flags_r <= `RST_PENDING_FLAGS;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // Configuration bytes change only on their own write strobe
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            enable_r   <= `RST_IRQ_ENABLE;
            priority_r <= `RST_IRQ_PRIORITY;
            pin_cfg_r  <= `RST_PIN_CONFIG;
        end
        else
        begin
            enable_r   <= enable_nxt;
            priority_r <= priority_nxt;
            pin_cfg_r  <= pin_cfg_nxt;
        end
    end

    // Registered read data keeps the bus output glitch free, at one cycle of latency
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rdata_r <= 8'h00;
        end
        else
        begin
            rdata_r <= rdata_nxt;
        end
    end

    // Previous empty level resets high so a holding register empty at start-up is no event
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            tx_empty_prev_r <= 1'b1;
        end
        else
        begin
            tx_empty_prev_r <= i_tx_holding_empty;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            freq_counter_irq_r <= 1'b0;
            spare_zero_irq_r   <= 1'b0;
            spare_one_irq_r    <= 1'b0;
            serializer_irq_r   <= 1'b0;
            edge_zero_irq_r    <= 1'b0;
            edge_one_irq_r     <= 1'b0;
        end
        else
        begin
            freq_counter_irq_r <= freq_counter_req;
            spare_zero_irq_r   <= spare_zero_req;
            spare_one_irq_r    <= spare_one_req;
            serializer_irq_r   <= serializer_req;
            edge_zero_irq_r    <= edge_zero_req;
            edge_one_irq_r     <= edge_one_req;
        end
    end

    // Capture triggers follow the raw edge events, independent of flags and masks
    always_ff @(posedge i_ref_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            capture_timer2_r <= 1'b0;
            capture_timer3_r <= 1'b0;
        end
        else
        begin
            capture_timer2_r <= event_zero;
            capture_timer3_r <= event_one;
        end
    end

    assign o_sfr_rdata              = rdata_r;
    assign o_freq_counter_irq       = freq_counter_irq_r;
    assign o_spare_zero_irq         = spare_zero_irq_r;
    assign o_spare_one_irq          = spare_one_irq_r;
    assign o_serializer_irq         = serializer_irq_r;
    assign o_edge_zero_irq          = edge_zero_irq_r;
    assign o_edge_one_irq           = edge_one_irq_r;
    assign o_freq_counter_high_prio = priority_r[`BIT_FREQ_COUNTER];
    assign o_spare_zero_high_prio   = priority_r[`BIT_SPARE_ZERO];
    assign o_spare_one_high_prio    = priority_r[`BIT_SPARE_ONE];
    assign o_capture_timer2         = capture_timer2_r;
    assign o_capture_timer3         = capture_timer3_r;

endmodule : ext_irq_flags_and_masks

// File: tb/ext_irq_checker.sv
// Port-level assertions for the extended interrupt flags block
`timescale 1ns/1ns
module ext_irq_checker
(
    input wire logic       i_ref_clk,
    input wire logic       i_reset_n,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic       i_global_irq_enable,
    input wire logic       i_edge_zero_irq_enable,
    input wire logic       i_serializer_irq_enable,
    input wire logic       i_freq_counter_flag,
    input wire logic       i_tx_holding_empty,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       o_freq_counter_irq,
    input wire logic       o_spare_zero_irq,
    input wire logic       o_serializer_irq,
    input wire logic       o_edge_zero_irq,
    input wire logic       o_spare_zero_high_prio,
    input wire logic       o_capture_timer2
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_zero_gate;
        i_edge_zero_irq_enable && i_global_irq_enable;
    endsequence
    sequence s_tx_rise;
        $rose(i_tx_holding_empty) && i_serializer_irq_enable && i_global_irq_enable;
    endsequence
    a_mapped_upper_zero: assert property (i_sfr_addr inside {8'hbf, 8'he6, 8'hf6} |=> o_sfr_rdata[7:5] == 3'h0)
        else $error("reserved bits read nonzero");
    a_unmapped_reads_zero: assert property (!(i_sfr_addr inside {8'hbf, 8'he6, 8'hf6, 8'hb7}) |=> o_sfr_rdata == 8'h00)
        else $error("unmapped address read nonzero");
    a_freq_irq_gate: assert property (o_freq_counter_irq |-> $past(i_freq_counter_flag && i_global_irq_enable))
        else $error("freq counter request without cause");
    a_global_blocks_all: assert property (!$past(i_global_irq_enable) |->
        !(o_freq_counter_irq || o_spare_zero_irq || o_serializer_irq || o_edge_zero_irq))
        else $error("request while global enable low");
    a_edge_irq_gate: assert property (o_edge_zero_irq |-> $past(i_edge_zero_irq_enable && i_global_irq_enable))
        else $error("edge request without enables");
    a_edge_sets_irq: assert property (o_capture_timer2 ##0 s_zero_gate |=> o_edge_zero_irq)
        else $error("edge event did not raise request");
    a_edge_flag_holds: assert property (
        o_edge_zero_irq && !$past(i_sfr_wr && i_sfr_addr == 8'hbf) ##0 s_zero_gate |=> o_edge_zero_irq)
        else $error("edge flag cleared without write");
    a_ser_flag_sets: assert property (s_tx_rise |-> ##[1:3] o_serializer_irq)
        else $error("empty holding register did not set flag");
    a_ser_irq_gate: assert property (o_serializer_irq |-> $past(i_serializer_irq_enable && i_global_irq_enable))
        else $error("serializer request without enables");
    a_prio_write_only: assert property ($changed(o_spare_zero_high_prio) |-> $past(i_sfr_wr && i_sfr_addr == 8'hf6))
        else $error("priority changed without write");
endmodule : ext_irq_checker

bind ext_irq_flags_and_masks ext_irq_checker ext_irq_checker_inst (.i_ref_clk, .i_reset_n, .i_sfr_addr, .i_sfr_wr,
    .i_global_irq_enable, .i_edge_zero_irq_enable, .i_serializer_irq_enable, .i_freq_counter_flag, .i_tx_holding_empty,
    .o_sfr_rdata, .o_freq_counter_irq, .o_spare_zero_irq, .o_serializer_irq, .o_edge_zero_irq,
    .o_spare_zero_high_prio, .o_capture_timer2);

// File: tb/gpio_cpu_model.sv
// GPIO pin drivers and timer capture counters on the block's far side
`timescale 1ns/1ns
`include "ext_irq_map.svh"
module gpio_cpu_model
(
    input  wire logic                   i_ref_clk,
    input  wire logic [`GPIO_COUNT-1:0] i_pin_req,
    input  wire logic                   i_capture_timer2,
    input  wire logic                   i_capture_timer3,
    output logic      [`GPIO_COUNT-1:0] o_gpio,
    output int                          o_cap2_cnt,
    output int                          o_cap3_cnt
);
    initial o_gpio = '0;
    initial o_cap2_cnt = 0;
    initial o_cap3_cnt = 0;
    // Levels move only at falling edges and are held for many cycles, far beyond the two-sample window
    always @(negedge i_ref_clk) o_gpio <= i_pin_req;
    always @(posedge i_ref_clk)
    begin
        o_cap2_cnt <= o_cap2_cnt + int'(i_capture_timer2);
        o_cap3_cnt <= o_cap3_cnt + int'(i_capture_timer3);
    end
endmodule : gpio_cpu_model

// File: tb/tb_top.sv
// Self-checking bench for the extended interrupt flags block
`timescale 1ns/1ns
`include "ext_irq_map.svh"
module tb_top;
    import ext_irq_pkg::*;
    logic                   i_ref_clk = 1'b0;
    logic                   i_reset_n = 1'b0;
    sfr_byte_t              i_sfr_addr = 8'h00;
    sfr_byte_t              i_sfr_wdata = 8'h00;
    logic                   i_sfr_wr = 1'b0;
    logic [`GPIO_COUNT-1:0] pin_req = '0;
    logic [`GPIO_COUNT-1:0] i_gpio;
    logic i_global_irq_enable = 1'b0, i_edge_zero_irq_enable = 1'b0, i_edge_one_irq_enable = 1'b0;
    logic i_serializer_irq_enable = 1'b0, i_dual_edge_sel_zero = 1'b0, i_dual_edge_sel_one = 1'b0;
    logic i_freq_counter_flag = 1'b0, i_tx_holding_empty = 1'b0;
    sfr_byte_t              o_sfr_rdata;
    logic o_freq_counter_irq, o_spare_zero_irq, o_spare_one_irq, o_serializer_irq, o_edge_zero_irq, o_edge_one_irq;
    logic o_freq_counter_high_prio, o_spare_zero_high_prio, o_spare_one_high_prio, o_capture_timer2, o_capture_timer3;
    int                     cap2, cap3, cycles = 0, n_mismatch = 0, checks_done = 0;

    ext_irq_flags_and_masks ext_irq_flags_and_masks_inst (.i_ref_clk, .i_reset_n, .i_sfr_addr, .i_sfr_wr,
        .i_sfr_wdata, .i_gpio, .i_global_irq_enable, .i_edge_zero_irq_enable, .i_edge_one_irq_enable,
        .i_serializer_irq_enable, .i_dual_edge_sel_zero, .i_dual_edge_sel_one, .i_freq_counter_flag,
        .i_tx_holding_empty, .o_sfr_rdata, .o_freq_counter_irq, .o_spare_zero_irq, .o_spare_one_irq,
        .o_serializer_irq, .o_edge_zero_irq, .o_edge_one_irq, .o_freq_counter_high_prio, .o_spare_zero_high_prio,
        .o_spare_one_high_prio, .o_capture_timer2, .o_capture_timer3);
    gpio_cpu_model gpio_cpu_model_inst (.i_ref_clk, .i_pin_req(pin_req), .i_capture_timer2(o_capture_timer2),
        .i_capture_timer3(o_capture_timer3), .o_gpio(i_gpio), .o_cap2_cnt(cap2), .o_cap3_cnt(cap3));

    initial forever #10 i_ref_clk = ~i_ref_clk;

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] seen);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask : wait_n

    task automatic wr(input sfr_byte_t a, input sfr_byte_t d);
        @(negedge i_ref_clk);
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_ref_clk);
        i_sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input sfr_byte_t a, input sfr_byte_t exp);
        @(negedge i_ref_clk);
        i_sfr_addr = a;
        @(negedge i_ref_clk);
        chk($sformatf("reg %h", a), exp, o_sfr_rdata);
    endtask : rd

    task automatic t_regs;
        rd(8'hbf, 8'h00);
        rd(8'he6, 8'h00);
        rd(8'hf6, 8'h00);
        rd(8'hb7, 8'h00);
        // Upper three bits kept clear on every write
        wr(8'he6, 8'hfc);
        wr(8'hf6, 8'hfc);
        rd(8'he6, 8'h1c);
        rd(8'hf6, 8'h1c);
        chk("prio", 8'h07, {5'h0, o_spare_one_high_prio, o_spare_zero_high_prio, o_freq_counter_high_prio});
        wr(8'hf6, 8'h08);
        wait_n(1);
        chk("prio", 8'h02, {5'h0, o_spare_one_high_prio, o_spare_zero_high_prio, o_freq_counter_high_prio});
        wr(8'h55, 8'hff);
        rd(8'h55, 8'h00);
        wr(8'he6, 8'h00);
        $display("test regs done");
    endtask : t_regs

    task automatic t_masks;
        i_global_irq_enable = 1'b1;
        i_freq_counter_flag = 1'b1;
        wr(8'he6, 8'h04);
        wait_n(2);
        chk("freq irq", 8'h01, {7'h0, o_freq_counter_irq});
        wr(8'he6, 8'h00);
        wait_n(2);
        chk("freq irq", 8'h00, {7'h0, o_freq_counter_irq});
        wr(8'hbf, 8'hf8);
        rd(8'hbf, 8'h18);
        wr(8'he6, 8'h18);
        wait_n(2);
        chk("spare irq", 8'h03, {6'h0, o_spare_one_irq, o_spare_zero_irq});
        wr(8'he6, 8'h08);
        wait_n(2);
        chk("spare irq", 8'h01, {6'h0, o_spare_one_irq, o_spare_zero_irq});
        i_global_irq_enable = 1'b0;
        wait_n(2);
        chk("spare irq", 8'h00, {6'h0, o_spare_one_irq, o_spare_zero_irq});
        i_freq_counter_flag = 1'b0;
        i_global_irq_enable = 1'b1;
        wr(8'hbf, 8'h00);
        wr(8'he6, 8'h00);
        $display("test masks done");
    endtask : t_masks

    task automatic t_serializer;
        i_serializer_irq_enable = 1'b1;
        i_tx_holding_empty = 1'b1;
        wait_n(4);
        chk("ser irq", 8'h01, {7'h0, o_serializer_irq});
        i_tx_holding_empty = 1'b0;
        rd(8'hbf, 8'h04);
        wr(8'hbf, 8'h00);
        wait_n(2);
        chk("ser irq", 8'h00, {7'h0, o_serializer_irq});
        $display("test serializer done");
    endtask : t_serializer

    task automatic t_edges;
        int pin;
        sfr_byte_t cfg;
        for (int s = 0; s < 2; s++)
            for (int c = 0; c < 8; c++)
            begin
                pin = (c == 5) ? (s == 1 ? 9 : 8) : c;
                // The idle source watches its alternate pin, which this pass never toggles
                cfg = (s == 1) ? {1'b0, 3'(c), 4'h5} : {4'h5, 1'b0, 3'(c)};
                wr(8'hb7, cfg);
                rd(8'hb7, cfg);
                pin_req <= `GPIO_COUNT'(1) << pin;
                wait_n(6);
                rd(8'hbf, (s == 1) ? 8'h02 : 8'h01);
                chk("captures", 8'(c + 1), 8'((s == 1) ? cap3 : cap2));
                wr(8'hbf, 8'h00);
                pin_req <= '0;
                wait_n(6);
                rd(8'hbf, 8'h00);
            end
        // Turning on invert with the pin low is itself a rising edge; clear it
        wr(8'hb7, 8'h58);
        wait_n(6);
        wr(8'hbf, 8'h00);
        i_edge_zero_irq_enable = 1'b1;
        pin_req <= `GPIO_COUNT'(1);
        wait_n(6);
        rd(8'hbf, 8'h00);
        pin_req <= '0;
        wait_n(6);
        rd(8'hbf, 8'h01);
        wait_n(10);
        chk("edge irq", 8'h01, {7'h0, o_edge_zero_irq});
        i_dual_edge_sel_zero = 1'b1;
        wr(8'hbf, 8'h00);
        pin_req <= `GPIO_COUNT'(1);
        wait_n(6);
        rd(8'hbf, 8'h01);
        wr(8'hbf, 8'h00);
        wait_n(2);
        chk("edge irq", 8'h00, {7'h0, o_edge_zero_irq});
        // Source one on its alternate pin: rising edge, then falling edge in dual mode
        i_edge_one_irq_enable = 1'b1;
        pin_req <= `GPIO_COUNT'(1) | (`GPIO_COUNT'(1) << `ALT_PIN_ONE);
        wait_n(6);
        chk("edge one irq", 8'h01, {7'h0, o_edge_one_irq});
        rd(8'hbf, 8'h02);
        i_dual_edge_sel_one = 1'b1;
        wr(8'hbf, 8'h00);
        pin_req <= `GPIO_COUNT'(1);
        wait_n(6);
        rd(8'hbf, 8'h02);
        chk("captures", 8'h0a, 8'(cap3));
        wr(8'hbf, 8'h00);
        wait_n(2);
        chk("edge one irq", 8'h00, {7'h0, o_edge_one_irq});
        $display("test edges done");
    endtask : t_edges

    always @(posedge i_ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    initial
    begin
        wait_n(10);
        i_reset_n = 1'b1;
        t_regs();
        t_masks();
        t_serializer();
        t_edges();
        end_sim();
    end
endmodule : tb_top
